// ===== iosarb_pkg.sv
// Package with record layout, codes and slot constants for the alarm record builder
// Notes on behaviour
// RULE1: The module type code of a removed or inserted module fills bytes x+4 to x+8 of the record.
// RULE2: The interrupt type byte at x+1 tells removal from insertion.
// RULE3: The high byte of the module type code goes to byte x+7.
// RULE4: The low byte of the module type code goes to byte x+8.
// RULE5: Bytes x+4 to x+6 of a remove/insert record are driven to zero.
// RULE6: An update interrupt is raised on wrong parameters or on a mismatch with stored module data.
// RULE7: Byte x+4 of an update record holds the index of the data record that caused it.
// RULE8: Byte x+5 of an update record holds the count of updates that could not be reported.
// RULE9: Two missing modules, a missing end module, too many modules or a bus fault stop the station.
// RULE10: Startup is not completed when one or more slots are empty at power-up.
// RULE11: An invalid configuration sets every bit of the ID diagnostic for slots 4 to 35.
// RULE12: Module status 01 is reported for slots before the failing slot.
// RULE13: Module status 11 is reported for the failing slot and all after it.
package iosarb_pkg;
    localparam int unsigned SLOT_FIRST = 4;
    localparam int unsigned SLOT_LAST = 35;
    localparam int unsigned SLOT_COUNT = SLOT_LAST - SLOT_FIRST + 1;
    localparam int unsigned SLOT_IDX_W = 5;
    localparam logic [7:0] ITYPE_INSERT = 8'h03;
    localparam logic [7:0] ITYPE_REMOVE = 8'h04;
    localparam logic [7:0] ITYPE_UPDATE = 8'h06;
    localparam logic [7:0] BYTE_UNUSED = 8'h00;
    localparam logic [1:0] MST_OK = 2'h0;
    localparam logic [1:0] MST_FAULT = 2'h1;
    localparam logic [1:0] MST_NONE = 2'h3;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [1:0] MISSING_LIMIT = 2'h2;
    localparam logic [31:0] ID_ALL_SET = 32'hFFFFFFFF;
endpackage : iosarb_pkg

// ===== iosarb_builder.sv
// Record builder for remove/insert and update interrupts and configuration diagnostics
`timescale 1ns/1ps
module iosarb_builder (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    // Remove/insert event
    input wire logic pull_evt_in,
    input wire logic pull_is_insert_in,
    input wire logic [15:0] module_type_code_in,
    // Update event
    input wire logic upd_evt_in,
    input wire logic upd_param_bad_in,
    input wire logic upd_mismatch_in,
    input wire logic [7:0] upd_index_in,
    input wire logic upd_lost_in,
    // Station configuration state
    input wire logic [1:0] missing_count_in,
    input wire logic end_module_missing_in,
    input wire logic too_many_modules_in,
    input wire logic backplane_fault_in,
    input wire logic powerup_in,
    input wire logic [4:0] fail_slot_in,
    // Record output
    output logic rec_valid_out,
    output logic [7:0] rec_type_out,
    output logic [7:0] rec_b4_out,
    output logic [7:0] rec_b5_out,
    output logic [7:0] rec_b6_out,
    output logic [7:0] rec_b7_out,
    output logic [7:0] rec_b8_out,
    // Diagnostics output
    output logic station_fail_out,
    output logic startup_ok_out,
    output logic [31:0] id_diag_out,
    output logic [63:0] mod_status_out
);
    logic rec_valid_q;
    logic [7:0] type_q, b4_q, b5_q, b6_q, b7_q, b8_q;
    logic [7:0] lost_q;
    logic fail_q, start_q, gap_q;
    logic [31:0] idd_q;
    logic [63:0] mst_q;
    logic [63:0] mst_d;
    wire upd_fire = upd_evt_in & (upd_param_bad_in | upd_mismatch_in); // RULE6
    wire invalid_cfg = (missing_count_in >= iosarb_pkg::MISSING_LIMIT) | end_module_missing_in
                     | too_many_modules_in | backplane_fault_in; // RULE9
    // A pull and an update in one cycle drop the update; it counts as lost like an outside loss
    wire upd_drop = upd_fire & pull_evt_in; // RULE8
    wire [8:0] lost_sum = {1'b0, lost_q}
                        + {7'h00, upd_lost_in & upd_drop, upd_lost_in ^ upd_drop};
    wire [7:0] lost_d = lost_sum[8] ? iosarb_pkg::CNT_MAX : lost_sum[7:0]; // RULE8

    // Status per slot index; index is relative to the first slot
    always_comb begin
        mst_d = '0;
        for (int i = 0; i < iosarb_pkg::SLOT_COUNT; i++) begin
            if (i < int'(fail_slot_in)) begin
                mst_d[2*i +: 2] = iosarb_pkg::MST_FAULT; // RULE12
            end else begin
                mst_d[2*i +: 2] = iosarb_pkg::MST_NONE; // RULE13
            end
        end
    end

    // Record bytes hold until the next record; only valid is a one-cycle pulse
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rec_valid_q <= 1'b0;
            type_q <= 8'h00;
            b4_q <= 8'h00;
            b5_q <= 8'h00;
            b6_q <= 8'h00;
            b7_q <= 8'h00;
            b8_q <= 8'h00;
        end else begin
            rec_valid_q <= pull_evt_in | upd_fire;
            if (pull_evt_in) begin
                // Remove/insert wins if both arrive; the update is counted as lost
                type_q <= pull_is_insert_in ? iosarb_pkg::ITYPE_INSERT
                                            : iosarb_pkg::ITYPE_REMOVE; // RULE2
                b4_q <= iosarb_pkg::BYTE_UNUSED; // RULE5 RULE1
                b5_q <= iosarb_pkg::BYTE_UNUSED; // RULE5
                b6_q <= iosarb_pkg::BYTE_UNUSED; // RULE5
                b7_q <= module_type_code_in[15:8]; // RULE3
                b8_q <= module_type_code_in[7:0]; // RULE4
            end else if (upd_fire) begin
                type_q <= iosarb_pkg::ITYPE_UPDATE;
                b4_q <= upd_index_in; // RULE7
                b5_q <= lost_q; // RULE8
                // Spare bytes are cleared so stale type code bytes never leak into an update
                b6_q <= iosarb_pkg::BYTE_UNUSED;
                b7_q <= iosarb_pkg::BYTE_UNUSED;
                b8_q <= iosarb_pkg::BYTE_UNUSED;
            end
        end
    end

    // Lost count saturates rather than wrapping so the master never sees a false low count
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lost_q <= 8'h00;
        end else begin
            lost_q <= lost_d; // RULE8
        end
    end

    // Diagnostics are registered so every status output changes on the same edge
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fail_q <= 1'b0;
            start_q <= 1'b0;
            gap_q <= 1'b0;
            idd_q <= 32'h0;
            mst_q <= 64'h0;
        end else begin
            fail_q <= invalid_cfg; // RULE9
            idd_q <= invalid_cfg ? iosarb_pkg::ID_ALL_SET : 32'h0; // RULE11
            mst_q <= invalid_cfg ? mst_d : 64'h0;
            if (powerup_in) begin
                gap_q <= (missing_count_in != 2'h0); // RULE10
            end
            // Power-up holds startup back one more cycle so the gap latch is read settled
            start_q <= ~invalid_cfg & ~powerup_in & ~gap_q; // RULE9 RULE10
        end
    end

    assign rec_valid_out = rec_valid_q;
    assign rec_type_out = type_q;
    assign rec_b4_out = b4_q;
    assign rec_b5_out = b5_q;
    assign rec_b6_out = b6_q;
    assign rec_b7_out = b7_q;
    assign rec_b8_out = b8_q;
    assign station_fail_out = fail_q;
    assign startup_ok_out = start_q;
    assign id_diag_out = idd_q;
    assign mod_status_out = mst_q;

    // Status pair at the failing slot and just before it, read by the slot checks
    wire [1:0] mst_at_slot = mod_status_out[{fail_slot_in, 1'b0} +: 2];
    wire [1:0] mst_before_slot = mod_status_out[{fail_slot_in - 5'h01, 1'b0} +: 2];

    // Remove/insert record checks
    a_ins_code_bytes: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE3
        pull_evt_in |=> rec_b7_out == $past(module_type_code_in[15:8])
                        && rec_b8_out == $past(module_type_code_in[7:0]))
        else $error("type code bytes wrong");
    a_ins_zero_pad: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE5
        pull_evt_in |=> rec_b4_out == 8'h00 && rec_b5_out == 8'h00 && rec_b6_out == 8'h00)
        else $error("pad bytes not zero");
    a_ins_type_byte: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE2
        pull_evt_in |=> rec_type_out == ($past(pull_is_insert_in) ? iosarb_pkg::ITYPE_INSERT
                                                                  : iosarb_pkg::ITYPE_REMOVE))
        else $error("interrupt type wrong");
    a_ins_full_code: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE1
        pull_evt_in |=> {rec_b4_out, rec_b5_out, rec_b6_out, rec_b7_out, rec_b8_out}
                        == {24'h000000, $past(module_type_code_in)})
        else $error("record code field wrong");
    a_ins_low_byte: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE4
        pull_evt_in |=> rec_b8_out == $past(module_type_code_in[7:0]))
        else $error("low type code byte wrong");

    // Update record and lost count checks
    a_upd_raise: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE6
        (upd_evt_in && !pull_evt_in && (upd_param_bad_in || upd_mismatch_in))
        |=> rec_valid_out && rec_type_out == iosarb_pkg::ITYPE_UPDATE)
        else $error("update not raised");
    a_upd_index: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE7
        (upd_fire && !pull_evt_in) |=> rec_b4_out == $past(upd_index_in))
        else $error("update index wrong");
    a_upd_lost: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE8
        (upd_fire && !pull_evt_in) |=> rec_b5_out == $past(lost_q))
        else $error("lost count wrong");
    a_upd_no_cause: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE6
        (!pull_evt_in && !(upd_evt_in && (upd_param_bad_in || upd_mismatch_in)))
        |=> !rec_valid_out)
        else $error("record without a cause");
    a_lost_drop: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE8
        (pull_evt_in && upd_evt_in && (upd_param_bad_in || upd_mismatch_in) && !upd_lost_in
            && lost_q != iosarb_pkg::CNT_MAX) |=> lost_q == $past(lost_q) + 8'h01)
        else $error("dropped update not counted");
    a_lost_idle: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE8
        (!upd_lost_in && !(pull_evt_in && upd_evt_in && (upd_param_bad_in || upd_mismatch_in)))
        |=> $stable(lost_q))
        else $error("lost count moved without a loss");

    // Configuration diagnostics checks
    a_cfg_fail: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE9
        (missing_count_in >= iosarb_pkg::MISSING_LIMIT || end_module_missing_in
            || too_many_modules_in || backplane_fault_in)
        |=> station_fail_out && !startup_ok_out)
        else $error("invalid config not failed");
    a_cfg_two_gone: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE9
        missing_count_in >= iosarb_pkg::MISSING_LIMIT |=> station_fail_out)
        else $error("two missing modules not failed");
    a_cfg_end_gone: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE9
        end_module_missing_in |=> station_fail_out)
        else $error("missing end module not failed");
    a_cfg_too_many: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE9
        too_many_modules_in |=> station_fail_out)
        else $error("too many modules not failed");
    a_cfg_bus_fault: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE9
        backplane_fault_in |=> station_fail_out)
        else $error("bus fault not failed");
    a_start_powerup: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE10
        powerup_in |=> !startup_ok_out)
        else $error("started during power-up");
    a_gap_start: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE10
        (powerup_in && missing_count_in != 2'h0) |=> ##1 !startup_ok_out)
        else $error("started with gap");
    a_id_diag: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE11
        invalid_cfg |=> id_diag_out == iosarb_pkg::ID_ALL_SET)
        else $error("id diag not all set");
    a_id_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE11
        !invalid_cfg |=> id_diag_out == 32'h00000000)
        else $error("id diag set without cause");
    a_mst_first: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE12
        (invalid_cfg && fail_slot_in != 5'h0) |=> mod_status_out[1:0] == iosarb_pkg::MST_FAULT)
        else $error("status before fail slot");
    a_mst_last: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE13
        invalid_cfg |=> mod_status_out[63:62] == iosarb_pkg::MST_NONE)
        else $error("status from fail slot");
    a_mst_at_fail: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE13
        invalid_cfg |=> ($stable(fail_slot_in) |-> mst_at_slot == iosarb_pkg::MST_NONE))
        else $error("status at fail slot");
    a_mst_before: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE12
        (invalid_cfg && fail_slot_in != 5'h00)
        |=> ($stable(fail_slot_in) |-> mst_before_slot == iosarb_pkg::MST_FAULT))
        else $error("status just before fail slot");
endmodule : iosarb_builder

// ===== iosarb_master.sv
// Fieldbus master stand-in that counts the records it receives and keeps the last one
`timescale 1ns/1ps
module iosarb_master (
    // Clock and record in
    input wire logic clk_in,
    input wire logic rec_valid_in,
    input wire logic [47:0] rec_in,
    // Captured record
    output logic [7:0] got_out = 8'h00,
    output logic [47:0] last_out = 48'h000000000000
);
    // Takes the record only in the one cycle that valid stands
    always @(posedge clk_in) begin
        if (rec_valid_in === 1'b1) begin
            got_out <= got_out + 8'h01;
            last_out <= rec_in;
        end
    end
endmodule : iosarb_master

// ===== iosarb_builder_test.sv
// Self-checking bench for the alarm record builder
`timescale 1ns/1ps
module iosarb_builder_test;
    logic clk_in = 1'b0, rst_b_in = 1'b0, pull_evt_in = 1'b0, pull_is_insert_in = 1'b0;
    logic upd_evt_in = 1'b0, upd_param_bad_in = 1'b0, upd_mismatch_in = 1'b0, upd_lost_in = 1'b0;
    logic end_module_missing_in = 1'b0, too_many_modules_in = 1'b0, backplane_fault_in = 1'b0;
    logic powerup_in = 1'b0, rec_valid_out, station_fail_out, startup_ok_out;
    logic [15:0] module_type_code_in = 16'h0000;
    logic [7:0] upd_index_in = 8'h00, rec_type_out, rec_b4_out, rec_b5_out, rec_b6_out;
    logic [7:0] rec_b7_out, rec_b8_out, got;
    logic [1:0] missing_count_in = 2'h0;
    logic [4:0] fail_slot_in = 5'h00;
    logic [31:0] id_diag_out;
    logic [63:0] mod_status_out, ms;
    logic [47:0] last;
    int mismatches = 0, checked = 0;
    always #2.5 clk_in = ~clk_in;
    iosarb_builder DUT (.clk_in, .rst_b_in, .pull_evt_in, .pull_is_insert_in, .module_type_code_in,
        .upd_evt_in, .upd_param_bad_in, .upd_mismatch_in, .upd_index_in, .upd_lost_in,
        .missing_count_in, .end_module_missing_in, .too_many_modules_in, .backplane_fault_in,
        .powerup_in, .fail_slot_in, .rec_valid_out, .rec_type_out, .rec_b4_out, .rec_b5_out,
        .rec_b6_out, .rec_b7_out, .rec_b8_out, .station_fail_out, .startup_ok_out,
        .id_diag_out, .mod_status_out);
    iosarb_master PEER (.clk_in, .rec_valid_in(rec_valid_out), .rec_in({rec_type_out,
        rec_b4_out, rec_b5_out, rec_b6_out, rec_b7_out, rec_b8_out}), .got_out(got),
        .last_out(last));
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // Bounded wait for the master to take one more record
    task automatic rec_wait(input logic [47:0] exp);
        logic [7:0] g0;
        g0 = got;
        for (int i = 0; i < 8 && got === g0; i++) @(posedge clk_in);
        #1;
        if (got === g0) begin
            mismatches++;
            end_of_test();
        end
        chk(last, exp);
    endtask : rec_wait
    task automatic pull(input logic ins, input logic [15:0] code, input logic [7:0] t);
        @(posedge clk_in);
        pull_evt_in <= 1'b1;
        pull_is_insert_in <= ins;
        module_type_code_in <= code;
        @(posedge clk_in);
        pull_evt_in <= 1'b0;
        rec_wait({t, 24'h000000, code});
    endtask : pull
    // A causeless event first: it must leave no record behind
    task automatic upd_test;
        logic [7:0] g0;
        g0 = got;
        @(posedge clk_in);
        upd_lost_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        upd_lost_in <= 1'b0;
        upd_evt_in <= 1'b1;
        @(posedge clk_in);
        upd_mismatch_in <= 1'b1;
        upd_index_in <= 8'h5A;
        @(posedge clk_in);
        upd_evt_in <= 1'b0;
        rec_wait({iosarb_pkg::ITYPE_UPDATE, 8'h5A, 8'h02, 24'h000000});
        chk(got, g0 + 8'h01);
    endtask : upd_test
    // Pull and caused update in one cycle: the pull's record goes out, the update counts as lost
    task automatic clash_test;
        @(posedge clk_in);
        pull_evt_in <= 1'b1;
        pull_is_insert_in <= 1'b0;
        module_type_code_in <= 16'h0F0F;
        upd_evt_in <= 1'b1;
        upd_mismatch_in <= 1'b0;
        upd_param_bad_in <= 1'b1;
        upd_index_in <= 8'h33;
        @(posedge clk_in);
        pull_evt_in <= 1'b0;
        upd_evt_in <= 1'b0;
        rec_wait({iosarb_pkg::ITYPE_REMOVE, 24'h000000, 16'h0F0F});
        @(posedge clk_in);
        upd_evt_in <= 1'b1;
        upd_index_in <= 8'hC4;
        @(posedge clk_in);
        upd_evt_in <= 1'b0;
        rec_wait({iosarb_pkg::ITYPE_UPDATE, 8'hC4, 8'h03, 24'h000000});
    endtask : clash_test
    task automatic cfg(input int c, input logic [4:0] fs);
        @(posedge clk_in);
        missing_count_in <= (c == 0) ? 2'h2 : 2'h0;
        end_module_missing_in <= (c == 1);
        too_many_modules_in <= (c == 2);
        backplane_fault_in <= (c == 3);
        fail_slot_in <= fs;
        for (int i = 0; i < 32; i++) ms[2*i+:2] = (i < fs) ? 2'h1 : 2'h3;
        repeat (2) @(posedge clk_in);
        #1;
        chk({station_fail_out, startup_ok_out}, 2'h2);
        chk(id_diag_out, 32'hFFFFFFFF);
        chk(mod_status_out, ms);
        @(posedge clk_in);
        {missing_count_in, end_module_missing_in, too_many_modules_in, backplane_fault_in} <= 5'h00;
        repeat (3) @(posedge clk_in);
        #1;
        chk({station_fail_out, startup_ok_out, id_diag_out}, 34'h100000000);
    endtask : cfg
    task automatic gap_test;
        @(posedge clk_in);
        powerup_in <= 1'b1;
        missing_count_in <= 2'h1;
        @(posedge clk_in);
        powerup_in <= 1'b0;
        missing_count_in <= 2'h0;
        repeat (4) @(posedge clk_in);
        #1;
        chk(startup_ok_out, 1'b0);
        @(posedge clk_in);
        powerup_in <= 1'b1;
        @(posedge clk_in);
        powerup_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        chk(startup_ok_out, 1'b1);
    endtask : gap_test
    initial begin
        repeat (4) @(posedge clk_in);
        chk({rec_valid_out, startup_ok_out, id_diag_out}, 34'h0);
        rst_b_in <= 1'b1;
        pull(1'b1, 16'hABCD, iosarb_pkg::ITYPE_INSERT);
        pull(1'b0, 16'h1234, iosarb_pkg::ITYPE_REMOVE);
        upd_test();
        clash_test();
        for (int c = 0; c < 4; c++) cfg(c, 5'(c * 31 / 3));
        gap_test();
        end_of_test();
    end
endmodule : iosarb_builder_test
